/* File: host_model.sv */
// Behavioural host processor that kicks the watchdog and drives the disable pin.
`timescale 1ns/10ps
module host_model #(
  parameter int PULSE = 17,
  parameter int GAP = 5
) (
  input wire logic clk_sys,  // System clock.
  input wire logic rst,  // Asynchronous reset, active high.
  input wire logic sys_reset_n,  // Reset seen by the host, active low.
  input wire logic kick_en,  // Bench lets the host run its kick loop.
  input wire logic dis_req,  // Bench asks the host to disable the watchdog.
  output logic watchdog_kick_in,  // Kick pin towards the supervisor.
  output logic watchdog_disable_in  // Disable pin towards the supervisor.
);
  int cnt;

  // A processor held in reset runs no code, so it kicks only while out of reset.
  // Pulses last 85 ns, the shortest width sure to be seen, and edges come far
  // closer together than one watchdog period.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cnt <= 0;
      watchdog_kick_in <= 1'b0;
    end else if (!sys_reset_n || !kick_en) begin
      cnt <= 0;
      watchdog_kick_in <= 1'b0;
    end else begin
      cnt <= (cnt == PULSE + GAP - 1) ? 0 : cnt + 1;
      watchdog_kick_in <= (cnt < PULSE);
    end
  end

  // The disable level follows the request one cycle later, well inside a period.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      watchdog_disable_in <= 1'b0;
    end else begin
      watchdog_disable_in <= dis_req;
    end
  end
endmodule : host_model

/* File: level_filter.sv */
// Two-stage synchroniser followed by a stability filter for one input pin.
`timescale 1ns/10ps
module level_filter #(
  parameter int STABLE_CYCLES = 1,
  parameter logic RESET_VAL = 1'b0
) (
  input wire logic clk_sys,  // System clock.
  input wire logic rst,  // Asynchronous reset, active high.
  input wire logic clk_en,  // Clock enable; state freezes while low.
  input wire logic raw,  // Pin level from outside the clock domain.
  output logic filt  // Level after synchronising and filtering.
);

  localparam int CNT_W = $clog2(STABLE_CYCLES + 1);

  logic sync_q1;
  logic sync_q2;
  logic [CNT_W-1:0] cnt;

  // A zero stability time would let a metastable sample straight through.
  if (STABLE_CYCLES < 1) begin : g_bad_stable
    $error("level_filter needs STABLE_CYCLES of at least one");
  end

  // The first stage feeds only the second stage.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sync_q1 <= RESET_VAL;
      sync_q2 <= RESET_VAL;
    end else if (clk_en) begin
      sync_q1 <= raw;
      sync_q2 <= sync_q1;
    end
  end

  // The output follows only a level that has differed for the whole stable time.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cnt <= '0;
      filt <= RESET_VAL;
    end else if (clk_en) begin
      if (sync_q2 == filt) begin
        cnt <= '0;
      end else if (cnt == CNT_W'(STABLE_CYCLES - 1)) begin
        cnt <= '0;
        filt <= sync_q2;
      end else begin
        cnt <= cnt + 1'b1;
      end
    end
  end

  a_filter_glitch: assert property (@(posedge clk_sys) disable iff (rst)
    (clk_en && $changed(filt)) |-> $past(sync_q2) == filt)
    else $error("filter output changed to a level not held by the synchroniser");

endmodule : level_filter

/* File: supervisor_pkg.sv */
// Shared constants and types of the reset supervisor with watchdog.
package supervisor_pkg;

  // Clock of the block.
  localparam int CLK_PERIOD_NS = 5;

  // Undervoltage must reach the reset output 23 us to 26 us after it appears.
  localparam int UV_ASSERT_MIN_NS = 23000;
  localparam int UV_ASSERT_MAX_NS = 26000;
  localparam int UV_FILTER_CYCLES = (UV_ASSERT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int UV_ASSERT_MAX_CYCLES = UV_ASSERT_MAX_NS / CLK_PERIOD_NS;

  // Manual reset low pulses up to 0.4 us are ignored.
  localparam int MR_GLITCH_NS = 400;
  localparam int MR_FILTER_CYCLES = MR_GLITCH_NS / CLK_PERIOD_NS + 1;

  // Shortest kick pulse that must be recognised.
  localparam int KICK_MIN_PULSE_NS = 85;
  localparam int KICK_MIN_PULSE_CYCLES = KICK_MIN_PULSE_NS / CLK_PERIOD_NS;

  // Internal time base: one tick per millisecond.
  localparam int TICK_NS = 1000000;
  localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;

  // Periods counted in time base ticks.
  localparam int TICK_COUNT_W = 17;
  localparam int WD_BASE_MS = 1600;
  localparam int WD_LONG_MS = 100000;
  localparam int RESET_TIMEOUT_MS = 200;

  // Reset values of the conditioned inputs.
  localparam logic UV_RESET_VAL = 1'b0;
  localparam logic MR_N_RESET_VAL = 1'b1;
  localparam logic KICK_RESET_VAL = 1'b0;
  localparam logic DIS_RESET_VAL = 1'b0;
  localparam logic SEL_RESET_VAL = 1'b0;

  // Reset sequencer states.
  typedef enum logic [1:0] {
    ST_HOLD,
    ST_TIMEOUT,
    ST_RUN
  } rst_state_t;

endpackage : supervisor_pkg

/* File: supervisor_reset_watchdog.sv */
// Reset supervisor: undervoltage, manual reset and watchdog driving one reset pin.
`timescale 1ns/10ps
module supervisor_reset_watchdog #(
  parameter int UV_FILTER_CYCLES = supervisor_pkg::UV_FILTER_CYCLES,
  parameter int MR_FILTER_CYCLES = supervisor_pkg::MR_FILTER_CYCLES,
  parameter int TICK_CYCLES = supervisor_pkg::TICK_CYCLES,
  parameter int WD_BASE_MS = supervisor_pkg::WD_BASE_MS,
  parameter int WD_LONG_MS = supervisor_pkg::WD_LONG_MS,
  parameter int RESET_TIMEOUT_MS = supervisor_pkg::RESET_TIMEOUT_MS
) (
  input wire logic clk_sys,  // System clock, 200 MHz.
  input wire logic rst,  // Asynchronous reset, active high; acts as power-up.
  input wire logic clk_en,  // Clock enable; all state freezes while low.
  input wire logic undervoltage_in,  // Comparator says monitored voltage is low.
  input wire logic manual_reset_n,  // Manual reset pin, active low.
  input wire logic watchdog_kick_in,  // Kick pin from the host.
  input wire logic watchdog_disable_in,  // High disables watchdog resets.
  input wire logic long_timeout_select,  // High selects the long watchdog period.
  output logic sys_reset_n,  // System reset level, active low.
  output logic reset_pin_out,  // Open-drain reset pin data, always low.
  output logic reset_pin_oe  // High while the reset pin is pulled low.
);

  localparam int CW = supervisor_pkg::TICK_COUNT_W;

  // Counts must fit the tick counters and the kick pulse must outlast the synchroniser.
  if (WD_LONG_MS >= (1 << CW) || WD_BASE_MS >= (1 << CW) || RESET_TIMEOUT_MS >= (1 << CW))
  begin : g_bad_period
    $error("watchdog or reset period does not fit the tick counter");
  end
  if (WD_BASE_MS < 1 || WD_LONG_MS < 1 || RESET_TIMEOUT_MS < 1) begin : g_bad_zero
    $error("periods must be at least one tick");
  end
  if (supervisor_pkg::KICK_MIN_PULSE_CYCLES < 2) begin : g_bad_kick
    $error("clock too slow to catch the shortest kick pulse");
  end

  logic uv_filt;
  logic mr_n_filt;
  logic kick_s;
  logic dis_s;
  logic sel_s;
  logic kick_prev;
  logic sel_prev;
  logic kick_edge;
  logic sel_change;
  logic cause;
  logic wd_clear;
  logic wd_run;
  logic [CW-1:0] wd_limit;
  logic [CW-1:0] wd_elapsed;
  logic wd_expired;
  logic rt_clear;
  logic rt_run;
  logic [CW-1:0] rt_elapsed;
  logic rt_done;
  logic wd_fire;
  supervisor_pkg::rst_state_t state;
  supervisor_pkg::rst_state_t next_state;

  // Undervoltage indication: must persist 23 us before it counts, so brief dips
  // are ignored while the reset still lands inside the 23 to 26 us window.
  level_filter #(
    .STABLE_CYCLES(UV_FILTER_CYCLES),
    .RESET_VAL(supervisor_pkg::UV_RESET_VAL)
  ) u_uv_filter (
    .clk_sys(clk_sys),
    .rst(rst),
    .clk_en(clk_en),
    .raw(undervoltage_in),
    .filt(uv_filt)
  );

  // Manual reset: low pulses shorter than the glitch time never reach the sequencer.
  level_filter #(
    .STABLE_CYCLES(MR_FILTER_CYCLES),
    .RESET_VAL(supervisor_pkg::MR_N_RESET_VAL)
  ) u_mr_filter (
    .clk_sys(clk_sys),
    .rst(rst),
    .clk_en(clk_en),
    .raw(manual_reset_n),
    .filt(mr_n_filt)
  );

  // Kick: a single stable cycle, so an 85 ns pulse of 17 cycles is always seen.
  level_filter #(
    .STABLE_CYCLES(1),
    .RESET_VAL(supervisor_pkg::KICK_RESET_VAL)
  ) u_kick_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .clk_en(clk_en),
    .raw(watchdog_kick_in),
    .filt(kick_s)
  );

  // Disable and select are slow straps from the host; plain synchronising suffices.
  level_filter #(
    .STABLE_CYCLES(1),
    .RESET_VAL(supervisor_pkg::DIS_RESET_VAL)
  ) u_dis_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .clk_en(clk_en),
    .raw(watchdog_disable_in),
    .filt(dis_s)
  );

  level_filter #(
    .STABLE_CYCLES(1),
    .RESET_VAL(supervisor_pkg::SEL_RESET_VAL)
  ) u_sel_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .clk_en(clk_en),
    .raw(long_timeout_select),
    .filt(sel_s)
  );

  // Previous levels for edge detection on kick and select.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      kick_prev <= supervisor_pkg::KICK_RESET_VAL;
      sel_prev <= supervisor_pkg::SEL_RESET_VAL;
    end else if (clk_en) begin
      kick_prev <= kick_s;
      sel_prev <= sel_s;
    end
  end

  // Both edge directions count, so one transition per period is enough.
  assign kick_edge = kick_s ^ kick_prev;
  assign sel_change = sel_s ^ sel_prev;

  // Level causes of reset.
  assign cause = uv_filt || !mr_n_filt;

  // The watchdog restarts on kicks, select changes and whenever reset is asserted,
  // which also covers undervoltage and manual reset; disabled, it stays at zero.
  assign wd_clear = kick_edge || sel_change || (state != supervisor_pkg::ST_RUN)
    || dis_s;
  assign wd_run = (state == supervisor_pkg::ST_RUN) && !dis_s;
  assign wd_limit = sel_s ? CW'(WD_LONG_MS) : CW'(WD_BASE_MS);

  tick_timer #(
    .TICK_CYCLES(TICK_CYCLES),
    .COUNT_W(CW)
  ) u_wd_timer (
    .clk_sys(clk_sys),
    .rst(rst),
    .clk_en(clk_en),
    .clear(wd_clear),
    .run(wd_run),
    .limit(wd_limit),
    .elapsed(wd_elapsed),
    .done(wd_expired)
  );

  // The reset timeout restarts whenever a cause reappears, so only an
  // uninterrupted quiet period releases reset.
  assign rt_clear = (state != supervisor_pkg::ST_TIMEOUT);
  assign rt_run = (state == supervisor_pkg::ST_TIMEOUT);

  tick_timer #(
    .TICK_CYCLES(TICK_CYCLES),
    .COUNT_W(CW)
  ) u_reset_timer (
    .clk_sys(clk_sys),
    .rst(rst),
    .clk_en(clk_en),
    .clear(rt_clear),
    .run(rt_run),
    .limit(CW'(RESET_TIMEOUT_MS)),
    .elapsed(rt_elapsed),
    .done(rt_done)
  );

  // A watchdog reset needs the counter to run out while the disable is low.
  assign wd_fire = wd_expired && !dis_s && !wd_clear;

  // Sequencer: hold while a cause stands, then time out, then run.
  always_comb begin
    next_state = state;
    unique case (state)
      supervisor_pkg::ST_HOLD: begin
        if (!cause) begin
          next_state = supervisor_pkg::ST_TIMEOUT;
        end
      end
      supervisor_pkg::ST_TIMEOUT: begin
        if (cause) begin
          next_state = supervisor_pkg::ST_HOLD;
        end else if (rt_done) begin
          next_state = supervisor_pkg::ST_RUN;
        end
      end
      supervisor_pkg::ST_RUN: begin
        if (cause) begin
          next_state = supervisor_pkg::ST_HOLD;
        end else if (wd_fire) begin
          next_state = supervisor_pkg::ST_TIMEOUT;
        end
      end
      // An illegal state code falls back into a full reset timeout.
      default: begin
        next_state = supervisor_pkg::ST_TIMEOUT;
      end
    endcase
  end

  // Power-up starts in the timeout state so the system sees a full reset pulse.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state <= supervisor_pkg::ST_TIMEOUT;
    end else if (clk_en) begin
      state <= next_state;
    end
  end

  // Reset outputs come straight from flip-flops to keep the pin glitch free.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sys_reset_n <= 1'b0;
      reset_pin_oe <= 1'b1;
    end else if (clk_en) begin
      sys_reset_n <= (next_state == supervisor_pkg::ST_RUN);
      reset_pin_oe <= (next_state != supervisor_pkg::ST_RUN);
    end
  end

  // The pin is open drain: it is only ever pulled low.
  assign reset_pin_out = 1'b0;

  // A standing reset cause must reach the pin one cycle after it is seen.
  a_uv_holds_reset: assert property (@(posedge clk_sys) disable iff (rst)
    (clk_en && uv_filt) |=> !sys_reset_n)
    else $error("reset not asserted during undervoltage");

  a_mr_holds_reset: assert property (@(posedge clk_sys) disable iff (rst)
    (clk_en && !mr_n_filt) |=> !sys_reset_n && reset_pin_oe)
    else $error("reset not asserted while manual reset is low");

  a_release_after_timeout: assert property (@(posedge clk_sys)
    disable iff (rst) $rose(sys_reset_n) |-> $past(rt_done)
    && $past(state) == supervisor_pkg::ST_TIMEOUT
    && $past(rt_elapsed) >= CW'(RESET_TIMEOUT_MS) && !$past(cause))
    else $error("reset released before the full reset timeout");

  a_kick_clears_wd: assert property (@(posedge clk_sys) disable iff (rst)
    (clk_en && kick_edge) |=> wd_elapsed == '0)
    else $error("kick edge did not clear the watchdog");

  a_sel_clears_wd: assert property (@(posedge clk_sys) disable iff (rst)
    (clk_en && sel_change) |=> wd_elapsed == '0)
    else $error("select change did not clear the watchdog");

  a_wd_expiry_resets: assert property (@(posedge clk_sys) disable iff (rst)
    (clk_en && state == supervisor_pkg::ST_RUN && wd_expired && !dis_s && !kick_edge
    && !sel_change) |=> !sys_reset_n ##1 state != supervisor_pkg::ST_RUN)
    else $error("watchdog expiry did not assert reset");

  a_wd_zero_in_reset: assert property (@(posedge clk_sys) disable iff (rst)
    (!sys_reset_n && !$past(sys_reset_n)) |-> wd_elapsed == '0)
    else $error("watchdog counted while reset was asserted");

  a_disable_blocks_wd: assert property (@(posedge clk_sys) disable iff (rst)
    (clk_en && state == supervisor_pkg::ST_RUN && dis_s && !cause) |=> sys_reset_n)
    else $error("watchdog reset while disabled");

  // A watchdog reset fires only once the count has reached the selected period.
  a_wd_limit_select: assert property (@(posedge clk_sys) disable iff (rst)
    (clk_en && wd_fire) |-> wd_elapsed == (sel_s ? CW'(WD_LONG_MS) : CW'(WD_BASE_MS)))
    else $error("watchdog period does not follow the select input");

  // The pin enable and the reset level are two views of one decision.
  a_pin_follows_reset: assert property (@(posedge clk_sys) disable iff (rst)
    reset_pin_oe == !sys_reset_n && !reset_pin_out)
    else $error("reset pin disagrees with the reset level");

  // A low clock enable must stretch every period rather than let it run on.
  a_enable_freeze: assert property (@(posedge clk_sys) disable iff (rst)
    !clk_en |=> $stable(sys_reset_n) && $stable(state) && $stable(wd_elapsed))
    else $error("state moved while the clock enable was low");

endmodule : supervisor_reset_watchdog

/* File: supervisor_reset_watchdog_tb.sv */
// Self-checking testbench of the reset supervisor driven by its host model.
`timescale 1ns/10ps
module supervisor_reset_watchdog_tb;
  localparam int TICK = 8;
  localparam int RTO = 2 * TICK;
  localparam int WD_BASE = 3 * TICK;
  localparam int WD_LONG = 7 * TICK;
  logic clk_sys, rst, clk_en, undervoltage_in, manual_reset_n, long_timeout_select;
  logic watchdog_kick_in, watchdog_disable_in, sys_reset_n, reset_pin_out, reset_pin_oe;
  logic kick_en, dis_req;
  int n_fail = 0;
  int checks = 0;
  int n;

  // Free-running 200 MHz clock.
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  supervisor_reset_watchdog #(.UV_FILTER_CYCLES(10), .MR_FILTER_CYCLES(5), .TICK_CYCLES(TICK),
    .WD_BASE_MS(3), .WD_LONG_MS(7), .RESET_TIMEOUT_MS(2)) supervisor_reset_watchdog_i (
    .clk_sys(clk_sys), .rst(rst), .clk_en(clk_en), .undervoltage_in(undervoltage_in),
    .manual_reset_n(manual_reset_n), .watchdog_kick_in(watchdog_kick_in),
    .watchdog_disable_in(watchdog_disable_in), .long_timeout_select(long_timeout_select),
    .sys_reset_n(sys_reset_n), .reset_pin_out(reset_pin_out), .reset_pin_oe(reset_pin_oe));

  host_model host_model_i (.clk_sys(clk_sys), .rst(rst),
    .sys_reset_n(sys_reset_n), .kick_en(kick_en), .dis_req(dis_req),
    .watchdog_kick_in(watchdog_kick_in), .watchdog_disable_in(watchdog_disable_in));

  // Prints the counts and the verdict; every path out of the run ends here.
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : close_out

  // Compares a measured delay in cycles against its allowed window.
  task automatic chk_range(input string what, input int got, input int lo, input int hi);
    checks++;
    if (got < lo || got > hi) begin
      $display("mismatch %s expected %0d..%0d seen %0d", what, lo, hi, got);
      n_fail++;
    end
  endtask : chk_range

  // Counts edges until reset shows lvl; a hang is cut short by the bound.
  task automatic wait_rst(input logic lvl, input int max, output int cnt);
    cnt = 0;
    while (sys_reset_n !== lvl) begin
      @(posedge clk_sys);
      #1;
      cnt++;
      if (cnt > max) begin
        $display("mismatch wait_reset expected %0b seen %0b", lvl, sys_reset_n);
        n_fail++;
        close_out();
      end
    end
  endtask : wait_rst

  // Reset level and both pin signals must stay put for the whole stretch.
  task automatic hold(input string what, input logic lvl, input int cyc);
    int bad;
    bad = 0;
    repeat (cyc) begin
      @(posedge clk_sys);
      #1;
      if (sys_reset_n !== lvl || reset_pin_oe !== ~lvl || reset_pin_out !== 1'b0) bad++;
    end
    checks++;
    if (bad != 0) begin
      $display("mismatch %s expected %0b seen %0b", what, lvl, sys_reset_n);
      n_fail++;
    end
  endtask : hold

  // Power-up release and a long kicked run without any reset.
  task automatic t_power_up();
    wait_rst(1'b1, 40, n);
    chk_range("power_up_release", n, RTO, RTO + 8);
    hold("kicked_run", 1'b1, 200);
    $display("test power_up done");
  endtask : t_power_up

  // Undervoltage glitch, assert delay, hold, interrupted and clean release.
  task automatic t_undervoltage();
    @(posedge clk_sys) undervoltage_in <= 1'b1;
    repeat (5) @(posedge clk_sys);
    undervoltage_in <= 1'b0;
    hold("uv_glitch", 1'b1, 30);
    @(posedge clk_sys) undervoltage_in <= 1'b1;
    wait_rst(1'b0, 40, n);
    chk_range("uv_assert_delay", n, 10, 16);
    hold("uv_hold", 1'b0, 40);
    @(posedge clk_sys) undervoltage_in <= 1'b0;
    // The dip outlasts the filter but returns before the timeout can run out.
    repeat (14) @(posedge clk_sys);
    undervoltage_in <= 1'b1;
    hold("uv_dip_in_timeout", 1'b0, 12);
    @(posedge clk_sys) undervoltage_in <= 1'b0;
    wait_rst(1'b1, 60, n);
    chk_range("uv_release", n, RTO + 10, RTO + 18);
    $display("test undervoltage done");
  endtask : t_undervoltage

  // Manual reset glitch, assert, hold and timed release.
  task automatic t_manual();
    @(posedge clk_sys) manual_reset_n <= 1'b0;
    repeat (3) @(posedge clk_sys);
    manual_reset_n <= 1'b1;
    hold("mr_glitch", 1'b1, 20);
    @(posedge clk_sys) manual_reset_n <= 1'b0;
    wait_rst(1'b0, 20, n);
    chk_range("mr_assert_delay", n, 5, 10);
    hold("mr_hold", 1'b0, 30);
    @(posedge clk_sys) manual_reset_n <= 1'b1;
    // Twenty frozen cycles inside the timeout must push the release out by as much.
    repeat (10) @(posedge clk_sys);
    clk_en <= 1'b0;
    hold("frozen_timeout", 1'b0, 19);
    @(posedge clk_sys) clk_en <= 1'b1;
    wait_rst(1'b1, 50, n);
    chk_range("mr_release", n, RTO - 5, RTO + 4);
    $display("test manual done");
  endtask : t_manual

  // Host stops kicking: base and long periods, and a select change mid-count.
  task automatic t_watchdog();
    @(posedge clk_sys) kick_en <= 1'b0;
    wait_rst(1'b0, 60, n);
    wait_rst(1'b1, 40, n);
    chk_range("wd_release", n, RTO, RTO + 6);
    wait_rst(1'b0, 60, n);
    chk_range("wd_base_period", n, WD_BASE, WD_BASE + 6);
    @(posedge clk_sys) long_timeout_select <= 1'b1;
    wait_rst(1'b1, 40, n);
    wait_rst(1'b0, 100, n);
    chk_range("wd_long_period", n, WD_LONG, WD_LONG + 6);
    wait_rst(1'b1, 40, n);
    repeat (15) @(posedge clk_sys);
    long_timeout_select <= 1'b0;
    wait_rst(1'b0, 60, n);
    chk_range("wd_select_restart", n, WD_BASE, WD_BASE + 6);
    $display("test watchdog done");
  endtask : t_watchdog

  // Disable raised right after release blocks the watchdog; lowering it restarts.
  task automatic t_disable();
    wait_rst(1'b1, 40, n);
    @(posedge clk_sys) dis_req <= 1'b1;
    hold("disabled_run", 1'b1, 150);
    @(posedge clk_sys) dis_req <= 1'b0;
    wait_rst(1'b0, 60, n);
    chk_range("wd_after_enable", n, WD_BASE, WD_BASE + 8);
    @(posedge clk_sys) kick_en <= 1'b1;
    wait_rst(1'b1, 40, n);
    hold("kicked_again", 1'b1, 100);
    $display("test disable done");
  endtask : t_disable

  // Main sequence: reset for six cycles, then every scenario in turn.
  initial begin
    rst = 1'b1;
    clk_en = 1'b1;
    undervoltage_in = 1'b0;
    manual_reset_n = 1'b1;
    long_timeout_select = 1'b0;
    kick_en = 1'b1;
    dis_req = 1'b0;
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    t_power_up();
    t_undervoltage();
    t_manual();
    t_watchdog();
    t_disable();
    close_out();
  end
endmodule : supervisor_reset_watchdog_tb

/* File: tick_timer.sv */
// Period timer that counts ticks of its own millisecond time base.
`timescale 1ns/10ps
module tick_timer #(
  parameter int TICK_CYCLES = 200000,
  parameter int COUNT_W = 17
) (
  input wire logic clk_sys,  // System clock.
  input wire logic rst,  // Asynchronous reset, active high.
  input wire logic clk_en,  // Clock enable; state freezes while low.
  input wire logic clear,  // Restart the period from zero.
  input wire logic run,  // Count while high.
  input wire logic [COUNT_W-1:0] limit,  // Period length in ticks.
  output logic [COUNT_W-1:0] elapsed,  // Whole ticks counted so far.
  output logic done  // Elapsed count has reached the limit.
);

  localparam int PRE_W = $clog2(TICK_CYCLES);

  logic [PRE_W-1:0] pre;

  if (TICK_CYCLES < 2) begin : g_bad_tick
    $error("tick_timer needs TICK_CYCLES of at least two");
  end

  // The prescaler restarts with the period so every tick is a whole one.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pre <= '0;
      elapsed <= '0;
    end else if (clk_en) begin
      if (clear || !run) begin
        pre <= '0;
        if (clear) begin
          elapsed <= '0;
        end
      end else if (pre == PRE_W'(TICK_CYCLES - 1)) begin
        pre <= '0;
        if (elapsed != '1) begin
          elapsed <= elapsed + 1'b1;
        end
      end else begin
        pre <= pre + 1'b1;
      end
    end
  end

  // Saturation keeps done high until the owner clears the timer.
  assign done = (elapsed >= limit);

endmodule : tick_timer
